// ===== hw/tlc_loop_ctrl.sv
// Operation
// RULE1 - Test bits 00 run pins normally; 01 floats all outputs and port pins
// RULE2 - Test bits 10 drive all outputs low, parallel port excluded
// RULE3 - Test bits 11 drive all outputs high, parallel port excluded
// RULE4 - Rate select bit clear means 1.544MHz, set means 2.048MHz system clock
// RULE5 - Local loop keeps transmitting and feeds transmitted data to the receiver
// RULE6 - Software puts the jitter attenuator in the transmit path for local loop
// RULE7 - Line loop retransmits recovered line data with bipolar violations kept
// RULE8 - Line loop keeps the receive path running and ignores transmit serial data
// RULE9 - Payload loop sends the 192 received payload bits back, violations corrected
// RULE10 - Payload loop regenerates framing, CRC and link bits instead of looping them; here ESF CRC slots are sent as 0 and link slots as 1
// RULE11 - Payload loop times the transmit line from the recovered receive clock
// RULE12 - Payload loop holds transmit channel clock and channel block low
// RULE13 - Payload loop times the transmit link clock from the recovered clock
// RULE14 - Payload loop ignores the transmit serial data input
// RULE15 - Framer loop feeds transmit side data into the receive side
// RULE16 - Framer loop sends unframed all ones unless line loop is active
// RULE17 - Framer loop ignores data on the receive line pins
// RULE18 - Framer loop drives receive clock output from the transmit clock
// RULE19 - Format bit 7 selects transmit D4 or ESF; bit 6 enables transmit B8ZS
// RULE20 - Format bit 5 enables Fs loading; bit 4 enables transmit link stuffer
// RULE21 - Format bit 3 selects receive D4 or ESF; bit 2 enables receive B8ZS
// RULE22 - Format bit 1 enables superframe-96 receive; bit 0 enables link destuffer
// RULE23 - Loop selections switch together on the next bit period boundary
`timescale 1ns/10ps
`default_nettype none
module tlc_loop_ctrl
  import tlc_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // Avalon-MM register slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             PORT_OE,
  // Line and backplane pin inputs
  input  wire logic        RX_LINE_POS,
  input  wire logic        RX_LINE_NEG,
  input  wire logic        RX_REC_CLOCK,
  input  wire logic        TX_SERIAL_IN,
  input  wire logic        TX_BIT_CLOCK,
  // Pin outputs, one shared enable
  output logic             TX_LINE_POS,
  output logic             TX_LINE_NEG,
  output logic             RX_SER_OUT,
  output logic             RX_CLK_OUT,
  output logic             TX_CHANNEL_CLOCK,
  output logic             TX_CHANNEL_BLOCK,
  output logic             TX_LINK_CLOCK,
  output logic             PIN_OE,
  // Configuration to neighbouring blocks
  output tlc_fmt_s         FORMAT_CTRL,
  output logic             TX_SLIP_BUFFER_EN,
  output logic             RX_SLIP_BUFFER_EN,
  output logic             RX_SIG_FORCE_ONES,
  output logic             SYS_CLOCK_RATE_SEL
);

  typedef struct packed {
    tlc_bus_e              bus;
    logic [7:0]            rdata;
    logic [1:0]            test;
    logic [7:0]            cc1;
    logic [7:0]            cc2;
    logic [TLC_N_IN-1:0]   sync_a;
    logic [TLC_N_IN-1:0]   sync_b;
    logic                  tx_bit_clock_prev;
    logic                  rclk_prev;
    tlc_loop_s             loop;
    logic [7:0]            frame_bit;
    logic [4:0]            frame_cnt;
    logic                  mark_neg;
    logic                  tx_data;
    tlc_pins_s             pins;
    logic                  pin_oe;
    logic                  port_oe;
  } tlc_state_s;

  tlc_state_s st;
  tlc_state_s next_st;

  // Framing bit for the current frame: regenerated, never looped
  function automatic logic f_bit(input logic esf, input logic [4:0] cnt);
    logic [2:0] fps_idx;
    fps_idx = cnt[4:2];
    if (!esf) begin
      f_bit = TLC_D4_PATTERN[4'(TLC_D4_LAST - cnt)];
    end else if (!cnt[0]) begin
      f_bit = 1'b1;
    end else if (cnt[1:0] == 2'h3) begin
      f_bit = TLC_FPS_PATTERN[3'(3'h5 - fps_idx)];
    end else begin
      f_bit = 1'b0;
    end
  endfunction

  logic tx_edge;
  logic rx_edge;
  logic tx_src_edge;
  logic rx_src_edge;
  logic line_pulse;
  logic tx_bit;
  logic rx_bit;
  logic [7:0] bit_in_chan;
  tlc_pins_s  pin_val;

  always_comb begin
    next_st = st;
    tx_bit = 1'b0;
    rx_bit = 1'b0;
    bit_in_chan = 8'h00;
    pin_val = st.pins;

    next_st.sync_a = {TX_BIT_CLOCK, TX_SERIAL_IN, RX_REC_CLOCK, RX_LINE_NEG, RX_LINE_POS};
    next_st.sync_b = st.sync_a;
    next_st.tx_bit_clock_prev = st.sync_b[TLC_IN_TX_BIT_CLOCK];
    next_st.rclk_prev = st.sync_b[TLC_IN_RCLK];
    tx_edge = st.sync_b[TLC_IN_TX_BIT_CLOCK] & ~st.tx_bit_clock_prev;
    rx_edge = st.sync_b[TLC_IN_RCLK] & ~st.rclk_prev;
    tx_src_edge = st.loop.payload_loop_en ? rx_edge : tx_edge; // RULE11
    rx_src_edge = st.loop.framer_loop_en ? tx_edge : rx_edge;  // RULE18
    line_pulse = st.sync_b[TLC_IN_RXP] | st.sync_b[TLC_IN_RXN];

    // Bus slave: one wait state, writes land on the first edge
    case (st.bus)
      TLC_BUS_IDLE: begin
        if (AVS_WRITE) begin
          next_st.bus = TLC_BUS_ACK;
          case (AVS_ADDRESS)
            TLC_ADDR_TEST: next_st.test = AVS_WRITEDATA[1:0];
            TLC_ADDR_CC1:  next_st.cc1 = AVS_WRITEDATA[7:0];
            TLC_ADDR_CC2:  next_st.cc2 = AVS_WRITEDATA[7:0]; // RULE19 RULE20 RULE21 RULE22
            default: ;
          endcase
        end else if (AVS_READ) begin
          next_st.bus = TLC_BUS_ACK;
          case (AVS_ADDRESS)
            TLC_ADDR_TEST: next_st.rdata = {6'h00, st.test};
            TLC_ADDR_CC1:  next_st.rdata = st.cc1;
            TLC_ADDR_CC2:  next_st.rdata = st.cc2;
            default:       next_st.rdata = 8'h00;
          endcase
        end
      end
      TLC_BUS_ACK: next_st.bus = TLC_BUS_IDLE;
      default:     next_st.bus = TLC_BUS_IDLE;
    endcase

    // All loop muxes move together, only on a bit boundary
    if (tx_edge | rx_edge) begin
      next_st.loop = '{local_loop_en:   st.cc1[TLC_CC1_LOCAL],
                       line_loop_en:    st.cc1[TLC_CC1_LINE],
                       payload_loop_en: st.cc1[TLC_CC1_PAYLOAD],
                       framer_loop_en:  st.cc1[TLC_CC1_FRAMER]}; // RULE23
    end

    // Transmit side
    if (tx_src_edge) begin
      if (st.frame_bit == TLC_F_SLOT) begin
        tx_bit = f_bit(st.cc2[7], st.frame_cnt); // RULE10 RULE19
      end else if (st.loop.payload_loop_en) begin
        tx_bit = line_pulse; // RULE9 RULE14
      end else begin
        tx_bit = st.sync_b[TLC_IN_TX_SERIAL_IN];
      end
      next_st.tx_data = tx_bit;
      if (st.frame_bit == TLC_FRAME_LAST) begin
        next_st.frame_bit = TLC_F_SLOT;
        if (st.frame_cnt == (st.cc2[7] ? TLC_ESF_LAST : TLC_D4_LAST)) begin
          next_st.frame_cnt = 5'h00;
        end else begin
          next_st.frame_cnt = st.frame_cnt + 5'h01;
        end
      end else begin
        next_st.frame_bit = st.frame_bit + 8'h01;
      end
      if (st.loop.line_loop_en) begin
        // Line data goes back unchanged; transmit serial input unused
        pin_val.tx_line_pos = st.sync_b[TLC_IN_RXP]; // RULE7 RULE8
        pin_val.tx_line_neg = st.sync_b[TLC_IN_RXN]; // RULE7
      end else begin
        if (st.loop.framer_loop_en) begin
          tx_bit = 1'b1; // RULE16
        end
        // AMI: marks alternate, so any looped violations are rebuilt clean
        pin_val.tx_line_pos = tx_bit & ~st.mark_neg;
        pin_val.tx_line_neg = tx_bit & st.mark_neg;
        next_st.mark_neg = st.mark_neg ^ tx_bit;
      end
    end

    // Receive side
    if (rx_src_edge) begin
      if (st.loop.framer_loop_en) begin
        rx_bit = st.tx_data; // RULE15 RULE17
      end else if (st.loop.local_loop_en) begin
        rx_bit = st.pins.tx_line_pos | st.pins.tx_line_neg; // RULE5
      end else begin
        rx_bit = line_pulse;
      end
      pin_val.rx_ser = rx_bit;
    end
    pin_val.rx_clk = st.loop.framer_loop_en ? st.sync_b[TLC_IN_TX_BIT_CLOCK] : st.sync_b[TLC_IN_RCLK]; // RULE18
    pin_val.tx_link_clock = st.loop.payload_loop_en ? st.sync_b[TLC_IN_RCLK] : st.sync_b[TLC_IN_TX_BIT_CLOCK]; // RULE13

    bit_in_chan = st.frame_bit - 8'h01;
    if (st.loop.payload_loop_en) begin
      pin_val.tx_channel_clock = 1'b0; // RULE12
      pin_val.tx_channel_block = 1'b0; // RULE12
    end else begin
      pin_val.tx_channel_clock = (st.frame_bit != TLC_F_SLOT) & ~bit_in_chan[2];
      pin_val.tx_channel_block = (st.frame_bit == TLC_F_SLOT);
    end

    // Pin test overrides apply to the registered pin image
    next_st.pins = pin_val;
    next_st.pin_oe = 1'b1;
    next_st.port_oe = 1'b1;
    case (st.test)
      TLC_PT_TRISTATE: begin
        next_st.pins = '0;
        next_st.pin_oe = 1'b0; // RULE1
        next_st.port_oe = 1'b0; // RULE1
      end
      TLC_PT_LOW:  next_st.pins = '0; // RULE2
      TLC_PT_HIGH: next_st.pins = '1; // RULE3
      default: ;
    endcase
    // Test mode forces rx_ser to the test level and holds the AMI mark polarity
    if (st.test != TLC_PT_NORMAL) begin
      next_st.pins.rx_ser = (st.test == TLC_PT_HIGH);
      next_st.mark_neg = st.mark_neg;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st <= '{bus: TLC_BUS_IDLE, rdata: TLC_CC_RESET, test: TLC_TEST_RESET,
              cc1: TLC_CC_RESET, cc2: TLC_CC_RESET, sync_a: '0, sync_b: '0,
              tx_bit_clock_prev: 1'b0, rclk_prev: 1'b0, loop: '0, frame_bit: TLC_F_SLOT,
              frame_cnt: 5'h00, mark_neg: 1'b0, tx_data: 1'b0, pins: '0,
              pin_oe: 1'b1, port_oe: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign AVS_WAITREQUEST   = (AVS_READ | AVS_WRITE) & (st.bus != TLC_BUS_ACK);
  assign AVS_READDATA      = {24'h000000, st.rdata};
  assign PORT_OE           = st.port_oe;
  assign TX_LINE_POS       = st.pins.tx_line_pos;
  assign TX_LINE_NEG       = st.pins.tx_line_neg;
  assign RX_SER_OUT        = st.pins.rx_ser;
  assign RX_CLK_OUT        = st.pins.rx_clk;
  assign TX_CHANNEL_CLOCK  = st.pins.tx_channel_clock;
  assign TX_CHANNEL_BLOCK  = st.pins.tx_channel_block;
  assign TX_LINK_CLOCK     = st.pins.tx_link_clock;
  assign PIN_OE            = st.pin_oe;
  assign FORMAT_CTRL       = tlc_fmt_s'(st.cc2); // RULE19 RULE20 RULE21 RULE22
  assign TX_SLIP_BUFFER_EN = st.cc1[TLC_CC1_TX_SLIP];
  assign RX_SLIP_BUFFER_EN = st.cc1[TLC_CC1_RX_SLIP];
  assign RX_SIG_FORCE_ONES = st.cc1[TLC_CC1_SIG_ONES];
  assign SYS_CLOCK_RATE_SEL = st.cc1[TLC_CC1_RATE]; // RULE4

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  chk_tristate_pins: assert property ((st.test == TLC_PT_TRISTATE) |=> (!PIN_OE && !PORT_OE && !TX_LINE_POS)) // RULE1
    else $error("Tristate test mode left a pin enabled");
  chk_force_low: assert property ((st.test == TLC_PT_LOW) |=> (PIN_OE && PORT_OE && !TX_LINE_NEG && !RX_CLK_OUT)) // RULE2
    else $error("Force-low test mode did not drive pins low");
  chk_force_high: assert property ((st.test == TLC_PT_HIGH) |=> (PIN_OE && TX_LINE_POS && TX_LINK_CLOCK && RX_SER_OUT)) // RULE3
    else $error("Force-high test mode did not drive pins high");
  chk_rate_select: assert property ((AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == TLC_ADDR_CC1)
    |-> (SYS_CLOCK_RATE_SEL == $past(AVS_WRITEDATA[TLC_CC1_RATE]))) // RULE4
    else $error("Rate select does not follow the written bit");
  chk_local_feed: assert property ((st.loop.local_loop_en && !st.loop.framer_loop_en && rx_src_edge
    && st.test == TLC_PT_NORMAL) |=> (RX_SER_OUT == $past(TX_LINE_POS | TX_LINE_NEG))) // RULE5
    else $error("Local loop did not feed transmitted data to receiver");
  chk_line_retx: assert property ((st.loop.line_loop_en && tx_src_edge && st.test == TLC_PT_NORMAL)
    |=> (TX_LINE_POS == $past(st.sync_b[TLC_IN_RXP]) && TX_LINE_NEG == $past(st.sync_b[TLC_IN_RXN]))) // RULE7
    else $error("Line loop did not retransmit line data unchanged");
  chk_payload_quiet: assert property ((st.loop.payload_loop_en && st.test == TLC_PT_NORMAL)
    |=> (!TX_CHANNEL_CLOCK && !TX_CHANNEL_BLOCK)) // RULE12
    else $error("Channel clock or block active in payload loop");
  chk_framer_ones: assert property ((st.loop.framer_loop_en && !st.loop.line_loop_en && tx_src_edge
    && st.test == TLC_PT_NORMAL) |=> (TX_LINE_POS ^ TX_LINE_NEG)) // RULE16
    else $error("Framer loop did not send a mark");
  chk_rx_clock_src: assert property ((st.loop.framer_loop_en && st.test == TLC_PT_NORMAL)
    |=> (RX_CLK_OUT == $past(st.sync_b[TLC_IN_TX_BIT_CLOCK]))) // RULE18
    else $error("Receive clock not taken from transmit clock in framer loop");
  chk_link_clock_src: assert property ((st.loop.payload_loop_en && st.test == TLC_PT_NORMAL)
    |=> (TX_LINK_CLOCK == $past(st.sync_b[TLC_IN_RCLK]))) // RULE13
    else $error("Link clock not timed by recovered clock in payload loop");
  chk_loop_switch: assert property (!(tx_edge || rx_edge) |=> $stable(st.loop)) // RULE23
    else $error("Loop routing changed off a bit boundary");

  cov_payload_loop: cover property (st.loop.payload_loop_en && tx_src_edge);
  cov_framer_line: cover property (st.loop.framer_loop_en && st.loop.line_loop_en);
  cov_local_loop: cover property (st.loop.local_loop_en && rx_src_edge);
  cov_bus_read: cover property (AVS_READ && !AVS_WAITREQUEST);

endmodule // tlc_loop_ctrl
`default_nettype wire

// ===== hw/tlc_pkg.sv
package tlc_pkg;

  // Register byte addresses
  localparam logic [7:0] TLC_ADDR_TEST = 8'h30;
  localparam logic [7:0] TLC_ADDR_CC1  = 8'h34;
  localparam logic [7:0] TLC_ADDR_CC2  = 8'h38;
  localparam logic [7:0] TLC_CC_RESET  = 8'h00;
  localparam logic [1:0] TLC_TEST_RESET = 2'h0;

  // Field positions of common_control_one
  localparam int TLC_CC1_TX_SLIP  = 7;
  localparam int TLC_CC1_LOCAL    = 6;
  localparam int TLC_CC1_SIG_ONES = 5;
  localparam int TLC_CC1_LINE     = 4;
  localparam int TLC_CC1_RATE     = 3;
  localparam int TLC_CC1_RX_SLIP  = 2;
  localparam int TLC_CC1_PAYLOAD  = 1;
  localparam int TLC_CC1_FRAMER   = 0;

  // Pin test codes {pin_test_sel_hi, pin_test_sel_lo}
  localparam logic [1:0] TLC_PT_NORMAL   = 2'h0;
  localparam logic [1:0] TLC_PT_TRISTATE = 2'h1;
  localparam logic [1:0] TLC_PT_LOW      = 2'h2;
  localparam logic [1:0] TLC_PT_HIGH     = 2'h3;

  // Frame geometry
  localparam logic [7:0]  TLC_FRAME_LAST = 8'hC0;
  localparam logic [7:0]  TLC_F_SLOT     = 8'h00;
  localparam logic [4:0]  TLC_ESF_LAST   = 5'h17;
  localparam logic [4:0]  TLC_D4_LAST    = 5'h0B;
  localparam logic [11:0] TLC_D4_PATTERN = 12'h8DC;
  localparam logic [5:0]  TLC_FPS_PATTERN = 6'h0B;

  // Indices of the pin inputs in the synchroniser vector
  localparam int TLC_IN_RXP  = 0;
  localparam int TLC_IN_RXN  = 1;
  localparam int TLC_IN_RCLK = 2;
  localparam int TLC_IN_TX_SERIAL_IN = 3;
  localparam int TLC_IN_TX_BIT_CLOCK = 4;
  localparam int TLC_N_IN    = 5;

  typedef enum logic [1:0] {
    TLC_BUS_IDLE = 2'b01,
    TLC_BUS_ACK  = 2'b10
  } tlc_bus_e;

  typedef struct packed {
    logic local_loop_en;
    logic line_loop_en;
    logic payload_loop_en;
    logic framer_loop_en;
  } tlc_loop_s;

  typedef struct packed {
    logic tx_frame_format_sel;
    logic tx_zero_subst_en;
    logic tx_fs_loading_en;
    logic tx_link_zero_stuff_en;
    logic rx_frame_format_sel;
    logic rx_zero_subst_en;
    logic rx_superframe96_en;
    logic rx_link_zero_destuff_en;
  } tlc_fmt_s;

  typedef struct packed {
    logic tx_line_pos;
    logic tx_line_neg;
    logic rx_ser;
    logic rx_clk;
    logic tx_channel_clock;
    logic tx_channel_block;
    logic tx_link_clock;
  } tlc_pins_s;

endpackage

// ===== verification/t1_loopback_mode_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module t1_loopback_mode_control_tb;
  import tlc_pkg::*;
  localparam int N = 960;
  logic        MCLK = 1'b0;
  logic        NRST = 1'b0;
  logic [7:0]  AVS_ADDRESS = 8'h00;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST, PORT_OE, PIN_OE;
  logic        RX_LINE_POS, RX_LINE_NEG, RX_REC_CLOCK, TX_SERIAL_IN, TX_BIT_CLOCK;
  logic        TX_LINE_POS, TX_LINE_NEG, RX_SER_OUT, RX_CLK_OUT;
  logic        TX_CHANNEL_CLOCK, TX_CHANNEL_BLOCK, TX_LINK_CLOCK;
  tlc_fmt_s    FORMAT_CTRL;
  logic        TX_SLIP_BUFFER_EN, RX_SLIP_BUFFER_EN, RX_SIG_FORCE_ONES, SYS_CLOCK_RATE_SEL;
  logic        run_tx = 1'b0;
  logic        run_rx = 1'b0;
  logic [2:0]  lvl = 3'h0;
  int          checks = 0;
  int          n_fail = 0;
  int          c_ser, c_mark, c_pos, c_rck, c_lck, c_ch;

  initial begin
    forever #25 MCLK = ~MCLK;
  end

  tlc_loop_ctrl u_dut (
    .MCLK(MCLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PORT_OE(PORT_OE), .RX_LINE_POS(RX_LINE_POS), .RX_LINE_NEG(RX_LINE_NEG), .RX_REC_CLOCK(RX_REC_CLOCK),
    .TX_SERIAL_IN(TX_SERIAL_IN), .TX_BIT_CLOCK(TX_BIT_CLOCK), .TX_LINE_POS(TX_LINE_POS),
    .TX_LINE_NEG(TX_LINE_NEG), .RX_SER_OUT(RX_SER_OUT), .RX_CLK_OUT(RX_CLK_OUT),
    .TX_CHANNEL_CLOCK(TX_CHANNEL_CLOCK), .TX_CHANNEL_BLOCK(TX_CHANNEL_BLOCK), .TX_LINK_CLOCK(TX_LINK_CLOCK),
    .PIN_OE(PIN_OE), .FORMAT_CTRL(FORMAT_CTRL), .TX_SLIP_BUFFER_EN(TX_SLIP_BUFFER_EN),
    .RX_SLIP_BUFFER_EN(RX_SLIP_BUFFER_EN), .RX_SIG_FORCE_ONES(RX_SIG_FORCE_ONES),
    .SYS_CLOCK_RATE_SEL(SYS_CLOCK_RATE_SEL)
  );

  tlc_line_model u_line (
    .mclk(MCLK), .run_tx(run_tx), .run_rx(run_rx), .lvl(lvl), .tx_bit_clock(TX_BIT_CLOCK),
    .rx_rec_clock(RX_REC_CLOCK), .rx_line_pos(RX_LINE_POS), .rx_line_neg(RX_LINE_NEG),
    .tx_serial_in(TX_SERIAL_IN)
  );

  task automatic summarize();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request holds until the rising edge that sees waitrequest low; data is taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int t;
    t = 0;
    @(posedge MCLK);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    do begin
      @(posedge MCLK);
      t++;
    end while (AVS_WAITREQUEST !== 1'b0 && t < 50);
    q = AVS_READDATA[7:0];
    if (t >= 50) n_fail++;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  // Loop bits change only at bit boundaries, so a few bit periods pass before watching
  task automatic run(input logic [7:0] cc1, input logic [2:0] lv, input logic rt, input logic rr, input int n);
    logic p_r;
    logic p_l;
    @(posedge MCLK);
    lvl <= lv;
    run_tx <= rt;
    run_rx <= rr;
    wr(TLC_ADDR_CC1, cc1);
    repeat (64) @(posedge MCLK);
    {c_ser, c_mark, c_pos, c_rck, c_lck, c_ch} = '0;
    p_r = RX_CLK_OUT;
    p_l = TX_LINK_CLOCK;
    repeat (n) begin
      @(negedge MCLK);
      c_ser += int'(RX_SER_OUT === 1'b1);
      c_mark += int'(TX_LINE_POS === 1'b1 || TX_LINE_NEG === 1'b1);
      c_pos += int'(TX_LINE_POS === 1'b1);
      c_rck += int'(RX_CLK_OUT === 1'b1 && p_r === 1'b0);
      c_lck += int'(TX_LINK_CLOCK === 1'b1 && p_l === 1'b0);
      c_ch += int'(TX_CHANNEL_CLOCK !== 1'b0 || TX_CHANNEL_BLOCK !== 1'b0);
      p_r = RX_CLK_OUT;
      p_l = TX_LINK_CLOCK;
    end
  endtask

  initial begin
    logic [7:0] v;
    repeat (5) @(posedge MCLK);
    NRST <= 1'b1;
    rd(TLC_ADDR_TEST, 8'h00);
    rd(TLC_ADDR_CC1, TLC_CC_RESET);
    rd(TLC_ADDR_CC2, TLC_CC_RESET);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h00);
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'hA5 : 8'h5A;
      wr(TLC_ADDR_CC2, v);
      rd(TLC_ADDR_CC2, v);
      chk(32'(FORMAT_CTRL), 32'(v));
    end
    wr(TLC_ADDR_CC1, 8'h08);
    chk(32'({TX_SLIP_BUFFER_EN, RX_SIG_FORCE_ONES, SYS_CLOCK_RATE_SEL, RX_SLIP_BUFFER_EN}), 32'h2);
    wr(TLC_ADDR_CC1, 8'hA4);
    chk(32'({TX_SLIP_BUFFER_EN, RX_SIG_FORCE_ONES, SYS_CLOCK_RATE_SEL, RX_SLIP_BUFFER_EN}), 32'hD);
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      wr(TLC_ADDR_TEST, 8'(m));
      repeat (3) @(posedge MCLK);
      chk(32'({PIN_OE, PORT_OE}), (m == 1) ? 32'h0 : 32'h3);
      if (m > 1) chk(32'({TX_LINE_POS, TX_LINE_NEG, RX_SER_OUT, RX_CLK_OUT, TX_CHANNEL_CLOCK,
                         TX_CHANNEL_BLOCK, TX_LINK_CLOCK}), (m == 3) ? 32'h7F : 32'h0);
      rd(TLC_ADDR_TEST, 8'(m));
    end
    wr(TLC_ADDR_TEST, 8'h00);
    $display("pin test done");
    run(8'h00, 3'b001, 1'b1, 1'b0, N);
    chk(32'({c_rck == 0, c_mark > N / 2, c_ch > 0, c_lck > 0}), 32'hF);
    run(8'h01, 3'b100, 1'b1, 1'b0, N);
    chk(32'(c_mark), 32'(N));
    chk(32'(c_rck > 0), 32'h1);
    chk(32'(c_ser < N / 4), 32'h1);
    run(8'h11, 3'b100, 1'b1, 1'b1, N);
    chk(32'(c_pos), 32'(N));
    run(8'h10, 3'b011, 1'b1, 1'b1, N);
    chk(32'({c_pos == 0, c_mark == N}), 32'h3);
    chk(32'(c_ser > N / 2), 32'h1);
    $display("framer and line loop done");
    wr(TLC_ADDR_CC2, 8'h80);
    run(8'h02, 3'b100, 1'b0, 1'b1, N);
    chk(32'(c_ch), 32'h0);
    chk(32'(c_lck > 0), 32'h1);
    chk(32'({c_pos > N / 4, c_mark - c_pos > N / 4}), 32'h3);
    run(8'h02, 3'b001, 1'b0, 1'b1, 6400);
    chk(32'(c_mark < 6400 / 4), 32'h1);
    chk(32'(c_mark > 0), 32'h1);
    $display("payload loop done");
    // Jitter attenuator sits outside this block; nothing in this run routes it to transmit
    run(8'h40, 3'b100, 1'b1, 1'b1, N);
    chk(32'(c_ser < N / 4), 32'h1);
    $display("local loop done");
    summarize();
  end

  initial begin
    repeat (60000) @(posedge MCLK);
    n_fail++;
    summarize();
  end
endmodule // t1_loopback_mode_control_tb
`default_nettype wire

// ===== verification/tlc_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module tlc_line_model (
  // Clock and control from the bench
  input  wire logic       mclk,
  input  wire logic       run_tx,
  input  wire logic       run_rx,
  input  wire logic [2:0] lvl,
  // Pins toward the block
  output logic            tx_bit_clock,
  output logic            rx_rec_clock,
  output logic            rx_line_pos,
  output logic            rx_line_neg,
  output logic            tx_serial_in
);
  logic [3:0] cnt_tx;
  logic [3:0] cnt_rx;

  initial begin
    cnt_tx = 4'h0;
    cnt_rx = 4'h0;
    tx_bit_clock = 1'b0;
    rx_rec_clock = 1'b0;
    {rx_line_pos, rx_line_neg, tx_serial_in} = 3'h0;
  end

  // Periods of 16 and 14 cycles keep the two bit clocks drifting apart
  always @(posedge mclk) begin
    cnt_tx <= run_tx ? cnt_tx + 4'h1 : 4'h0;
    cnt_rx <= (!run_rx || cnt_rx == 4'hD) ? 4'h0 : cnt_rx + 4'h1;
    // A stopped clock stands low, as between frames on a real line
    tx_bit_clock <= run_tx & cnt_tx[3];
    rx_rec_clock <= run_rx & (cnt_rx > 4'h6);
    {rx_line_pos, rx_line_neg, tx_serial_in} <= lvl;
  end
endmodule // tlc_line_model
`default_nettype wire
